// *** hw/bias_regs_defines.svh ***
`ifndef BIAS_REGS_DEFINES_SVH
`define BIAS_REGS_DEFINES_SVH

// ****************************************************************
// register addresses
// ****************************************************************
`define ADDR_NEG_BIAS      8'h0e
`define ADDR_FAULT         8'h0f
`define ADDR_OPT1          8'h10
`define ADDR_OPT2          8'h11
`define ADDR_CODE_LO       8'h12
`define ADDR_CODE_HI       8'h13

// ****************************************************************
// reset values and negative bias clamp limit
// ****************************************************************
`define RST_NEG_BIAS       6'h1c
`define RST_OPT1           8'h06
`define RST_OPT2           8'h35
`define NEG_BIAS_MAX       6'h32

// ****************************************************************
// field positions
// ****************************************************************
`define FLT_THERMAL        6
`define FLT_DISP_OVP       5
`define FLT_POS_OCP        3
`define FLT_NEG_SHORT      2
`define FLT_BACKLIGHT_OVERVOLTAGE_FLAG         1
`define FLT_BACKLIGHT_OVERCURRENT_FLAG         0
`define OPT1_STR2          4
`define OPT1_STR1          3
`define OPT1_FAST          0

`endif

// *** hw/bias_regs_pkg.sv ***
package bias_regs_pkg;
  typedef enum logic [1:0] {
    GLITCH_NONE = 2'h0,
    GLITCH_100  = 2'h1,
    GLITCH_150  = 2'h2,
    GLITCH_200  = 2'h3
  } glitch_sel_t;

  typedef enum logic [1:0] {
    IND_4U7 = 2'h0,
    IND_10U = 2'h1,
    IND_15U = 2'h2
  } inductor_sel_t;

  typedef enum logic [1:0] {
    ILIM_0A9 = 2'h0,
    ILIM_1A2 = 2'h1,
    ILIM_1A5 = 2'h2,
    ILIM_1A8 = 2'h3
  } ilim_sel_t;
endpackage

// *** hw/reg_port_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface reg_port_if;
  logic       wr_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       hit;
  modport bank (input wr_en, input addr, input wdata, output rdata, output hit);
  modport ctrl (output wr_en, output addr, output wdata, input rdata, input hit);
endinterface
`default_nettype wire

// *** hw/status_capture.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "bias_regs_defines.svh"
module status_capture (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [5:0]  fault_in,
  input  wire logic [10:0] measured_duty_code,
  output logic      [7:0]  fault_r,
  output logic      [10:0] code_r
);
  import bias_regs_pkg::*;

  // ****************************************************************
  // live fault image and code sampling
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fault_r <= 8'h00;
    end else begin
      fault_r <= {1'b0, fault_in[5:4], 1'b0, fault_in[3:0]};
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      code_r <= 11'h000;
    end else begin
      code_r <= measured_duty_code;
    end
  end
endmodule
`default_nettype wire

// *** hw/bias_status_option_regs.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "bias_regs_defines.svh"
module bias_status_option_regs (
  input  wire logic                          mclk,
  input  wire logic                          rst_n,
  input  wire logic                          reg_wr_en,
  input  wire logic [7:0]                    reg_addr,
  input  wire logic [7:0]                    reg_wdata,
  output logic      [7:0]                    reg_rdata,
  output logic                               reg_hit,
  input  wire logic                          thermal_trip_flag,
  input  wire logic                          display_boost_overvoltage_flag,
  input  wire logic                          positive_bias_overcurrent_flag,
  input  wire logic                          negative_bias_short_flag,
  input  wire logic                          backlight_overvoltage_flag,
  input  wire logic                          backlight_overcurrent_flag,
  input  wire logic [10:0]                   measured_duty_code,
  output logic      [5:0]                    negative_bias_output,
  output logic                               string_two_sense_off,
  output logic                               string_one_sense_off,
  output bias_regs_pkg::glitch_sel_t         pwm_glitch_width_select,
  output logic                               pwm_fast_sampling_select,
  output bias_regs_pkg::inductor_sel_t       inductor_select,
  output logic      [1:0]                    loop_gain_p,
  output logic      [1:0]                    loop_gain_i,
  output bias_regs_pkg::ilim_sel_t           switch_current_limit
);
  import bias_regs_pkg::*;

  logic [5:0]  neg_bias_r;
  logic [7:0]  opt1_r;
  logic [7:0]  opt2_r;
  logic [7:0]  fault_r;
  logic [10:0] code_r;
  logic [7:0]  rdata_nxt;

  reg_port_if rp ();
  assign rp.wr_en = reg_wr_en;
  assign rp.addr  = reg_addr;
  assign rp.wdata = reg_wdata;

  function automatic logic is_writable(input logic [7:0] a);
    is_writable = (a == `ADDR_NEG_BIAS) || (a == `ADDR_OPT1) || (a == `ADDR_OPT2);
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = is_writable(a) || (a == `ADDR_FAULT) || (a == `ADDR_CODE_LO) || (a == `ADDR_CODE_HI);
  endfunction

  // ****************************************************************
  // status capture
  // ****************************************************************
  status_capture u_cap (
    .mclk               (mclk),
    .rst_n              (rst_n),
    .fault_in           ({thermal_trip_flag, display_boost_overvoltage_flag,
                          positive_bias_overcurrent_flag, negative_bias_short_flag,
                          backlight_overvoltage_flag, backlight_overcurrent_flag}),
    .measured_duty_code (measured_duty_code),
    .fault_r            (fault_r),
    .code_r             (code_r)
  );

  // ****************************************************************
  // writable registers
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      neg_bias_r <= `RST_NEG_BIAS;
    end else if (rp.wr_en && rp.addr == `ADDR_NEG_BIAS) begin
      neg_bias_r <= rp.wdata[5:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      opt1_r <= `RST_OPT1;
    end else if (rp.wr_en && rp.addr == `ADDR_OPT1) begin
      opt1_r <= {1'b0, rp.wdata[6:0]};
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      opt2_r <= `RST_OPT2;
    end else if (rp.wr_en && rp.addr == `ADDR_OPT2) begin
      opt2_r <= rp.wdata;
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  always_comb begin
    case (rp.addr)
      `ADDR_NEG_BIAS: rdata_nxt = {2'h0, neg_bias_r};
      `ADDR_FAULT:    rdata_nxt = fault_r;
      `ADDR_OPT1:     rdata_nxt = opt1_r;
      `ADDR_OPT2:     rdata_nxt = opt2_r;
      `ADDR_CODE_LO:  rdata_nxt = code_r[7:0];
      `ADDR_CODE_HI:  rdata_nxt = {5'h00, code_r[10:8]};
      default:        rdata_nxt = 8'h00;
    endcase
  end

  assign rp.rdata = rdata_nxt;
  assign rp.hit   = is_mapped(rp.addr);
  assign reg_rdata = rp.rdata;
  assign reg_hit   = rp.hit;

  // ****************************************************************
  // control outputs
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      negative_bias_output <= `RST_NEG_BIAS;
    end else begin
      negative_bias_output <= (neg_bias_r > `NEG_BIAS_MAX) ? `NEG_BIAS_MAX : neg_bias_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      string_two_sense_off     <= 1'b0;
      string_one_sense_off     <= 1'b0;
      pwm_glitch_width_select  <= GLITCH_200;
      pwm_fast_sampling_select <= 1'b0;
    end else begin
      string_two_sense_off     <= opt1_r[`OPT1_STR2];
      string_one_sense_off     <= opt1_r[`OPT1_STR1];
      pwm_glitch_width_select  <= glitch_sel_t'(opt1_r[2:1]);
      pwm_fast_sampling_select <= opt1_r[`OPT1_FAST];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      inductor_select      <= IND_4U7;
      loop_gain_p          <= 2'h3;
      loop_gain_i          <= 2'h1;
      switch_current_limit <= ILIM_1A2;
    end else begin
      inductor_select      <= opt2_r[7] ? IND_15U : inductor_sel_t'(opt2_r[7:6]);
      loop_gain_p          <= opt2_r[5:4];
      loop_gain_i          <= opt2_r[3:2];
      switch_current_limit <= ilim_sel_t'(opt2_r[1:0]);
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_ro_write;
    reg_wr_en && (reg_addr == `ADDR_FAULT || reg_addr == `ADDR_CODE_LO || reg_addr == `ADDR_CODE_HI);
  endsequence

  sequence s_neg_write;
    reg_wr_en && reg_addr == `ADDR_NEG_BIAS;
  endsequence

  sequence s_opt1_write;
    reg_wr_en && reg_addr == `ADDR_OPT1;
  endsequence

  sequence s_opt2_write;
    reg_wr_en && reg_addr == `ADDR_OPT2;
  endsequence

  AST_NEG_CLAMP: assert property (@(posedge mclk) disable iff (!rst_n)
    negative_bias_output <= `NEG_BIAS_MAX) else $error("negative bias code exceeds clamp");
  AST_NEG_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_wr_en && reg_addr == `ADDR_NEG_BIAS && reg_wdata[5:0] <= `NEG_BIAS_MAX
    |-> ##2 negative_bias_output == $past(reg_wdata[5:0], 2)) else $error("negative bias not applied");
  AST_THERMAL: assert property (@(posedge mclk) disable iff (!rst_n)
    rst_n && thermal_trip_flag |=> fault_r[`FLT_THERMAL]) else $error("thermal bit missing");
  AST_DISP_OVP: assert property (@(posedge mclk) disable iff (!rst_n)
    rst_n |=> fault_r[`FLT_DISP_OVP] == $past(display_boost_overvoltage_flag)) else $error("display ovp bit wrong");
  AST_POS_OCP: assert property (@(posedge mclk) disable iff (!rst_n)
    rst_n |=> fault_r[`FLT_POS_OCP] == $past(positive_bias_overcurrent_flag)) else $error("positive ocp bit wrong");
  AST_NEG_SHORT: assert property (@(posedge mclk) disable iff (!rst_n)
    rst_n |=> fault_r[`FLT_NEG_SHORT] == $past(negative_bias_short_flag)) else $error("negative short bit wrong");
  AST_BL_FLAGS: assert property (@(posedge mclk) disable iff (!rst_n)
    rst_n |=> fault_r[1:0] == $past({backlight_overvoltage_flag, backlight_overcurrent_flag})) else $error("bl bits wrong");
  AST_RO_IGNORED: assert property (@(posedge mclk) disable iff (!rst_n)
    s_ro_write |=> neg_bias_r == $past(neg_bias_r))
    else $error("read-only write disturbed state");
  AST_INDUCTOR: assert property (@(posedge mclk) disable iff (!rst_n)
    opt2_r[7] |=> inductor_select == IND_15U) else $error("inductor select not 15 uH");
  AST_HIGH_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_addr == `ADDR_CODE_HI |-> reg_rdata[7:3] == 5'h00 && reg_rdata[2:0] == code_r[10:8])
    else $error("high readback reserved bits set");
  AST_SENSE: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_wr_en && reg_addr == `ADDR_OPT1 |-> ##2 string_two_sense_off == $past(reg_wdata[4], 2))
    else $error("string two sense not applied");

  // ****************************************************************
  // assertions on bias code path
  // ****************************************************************
  AST_NEG_STORE: assert property (@(posedge mclk) disable iff (!rst_n)
    s_neg_write
    |=> neg_bias_r == $past(reg_wdata[5:0]))
    else $error("negative bias code not stored");

  AST_NEG_LIMIT: assert property (@(posedge mclk) disable iff (!rst_n)
    s_neg_write ##0 (reg_wdata[5:0] > `NEG_BIAS_MAX)
    |-> ##2 negative_bias_output == `NEG_BIAS_MAX)
    else $error("negative bias code not clamped");

  AST_NEG_READ: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_addr == `ADDR_NEG_BIAS
    |-> reg_rdata == {2'h0, neg_bias_r})
    else $error("negative bias readback wrong");

  AST_NEG_RESET: assert property (@(posedge mclk)
    !rst_n
    |=> neg_bias_r == `RST_NEG_BIAS && negative_bias_output == `RST_NEG_BIAS)
    else $error("negative bias reset value wrong");

  // ****************************************************************
  // assertions on fault image
  // ****************************************************************
  AST_THERMAL_CLR: assert property (@(posedge mclk) disable iff (!rst_n)
    rst_n && !thermal_trip_flag
    |=> !fault_r[`FLT_THERMAL])
    else $error("thermal bit stuck");

  AST_FAULT_SPARE: assert property (@(posedge mclk) disable iff (!rst_n)
    s_ro_write
    |=> fault_r[7] == 1'b0 && fault_r[4] == 1'b0)
    else $error("unused fault bits set");

  AST_RO_FAULT: assert property (@(posedge mclk) disable iff (!rst_n)
    s_ro_write
    |=> fault_r[6:5] == $past({thermal_trip_flag, display_boost_overvoltage_flag})
        && fault_r[3:0] == $past({positive_bias_overcurrent_flag, negative_bias_short_flag,
                                  backlight_overvoltage_flag, backlight_overcurrent_flag}))
    else $error("fault image disturbed by write");

  AST_FAULT_RESET: assert property (@(posedge mclk)
    !rst_n
    |=> fault_r == 8'h00)
    else $error("fault image not cleared by reset");

  // ****************************************************************
  // assertions on option decode
  // ****************************************************************
  AST_STR1: assert property (@(posedge mclk) disable iff (!rst_n)
    s_opt1_write
    |-> ##2 string_one_sense_off == $past(reg_wdata[`OPT1_STR1], 2))
    else $error("string one sense not applied");

  AST_GLITCH: assert property (@(posedge mclk) disable iff (!rst_n)
    s_opt1_write
    |-> ##2 pwm_glitch_width_select == $past(reg_wdata[2:1], 2))
    else $error("glitch filter select not applied");

  AST_FAST: assert property (@(posedge mclk) disable iff (!rst_n)
    s_opt1_write
    |-> ##2 pwm_fast_sampling_select == $past(reg_wdata[`OPT1_FAST], 2))
    else $error("fast sampling select not applied");

  AST_OPT1_TOP: assert property (@(posedge mclk) disable iff (!rst_n)
    s_opt1_write
    |=> opt1_r[7] == 1'b0 && opt1_r[6:0] == $past(reg_wdata[6:0]))
    else $error("option one store wrong");

  AST_OPT2_STORE: assert property (@(posedge mclk) disable iff (!rst_n)
    s_opt2_write
    |=> opt2_r == $past(reg_wdata))
    else $error("option two store wrong");

  AST_INDUCTOR_LOW: assert property (@(posedge mclk) disable iff (!rst_n)
    s_opt2_write ##0 !reg_wdata[7]
    |-> ##2 inductor_select == $past(reg_wdata[7:6], 2))
    else $error("inductor select not applied");

  AST_ILIM: assert property (@(posedge mclk) disable iff (!rst_n)
    s_opt2_write
    |-> ##2 switch_current_limit == $past(reg_wdata[1:0], 2))
    else $error("current limit not applied");

  AST_GAINS: assert property (@(posedge mclk) disable iff (!rst_n)
    s_opt2_write
    |-> ##2 loop_gain_p == $past(reg_wdata[5:4], 2) && loop_gain_i == $past(reg_wdata[3:2], 2))
    else $error("loop settings not applied");

  AST_OPT_RESET: assert property (@(posedge mclk)
    !rst_n
    |=> opt1_r == `RST_OPT1 && opt2_r == `RST_OPT2)
    else $error("option reset value wrong");

  AST_OUT_RESET: assert property (@(posedge mclk)
    !rst_n
    |=> pwm_glitch_width_select == GLITCH_200 && switch_current_limit == ILIM_1A2
        && inductor_select == IND_4U7)
    else $error("decoded outputs not at reset value");

  AST_SENSE_RESET: assert property (@(posedge mclk)
    !rst_n
    |=> !string_two_sense_off && !string_one_sense_off && !pwm_fast_sampling_select)
    else $error("sense outputs not at reset value");

  // ****************************************************************
  // assertions on readback and decode
  // ****************************************************************
  AST_CODE_LOW: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_addr == `ADDR_CODE_LO
    |-> reg_rdata == code_r[7:0])
    else $error("low readback wrong");

  AST_CODE_TRACK: assert property (@(posedge mclk) disable iff (!rst_n)
    rst_n
    |=> code_r == $past(measured_duty_code))
    else $error("duty code not captured");

  AST_CODE_RESET: assert property (@(posedge mclk)
    !rst_n
    |=> code_r == 11'h000)
    else $error("duty code not cleared by reset");

  AST_UNMAPPED: assert property (@(posedge mclk) disable iff (!rst_n)
    !reg_hit
    |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  AST_HIT: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_hit == (reg_addr >= `ADDR_NEG_BIAS && reg_addr <= `ADDR_CODE_HI))
    else $error("address hit wrong");
endmodule
`default_nettype wire

// *** sim/reg_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "bias_regs_defines.svh"
// ****************************************
// host side of the register port
// ****************************************
module reg_host_model (
  input  wire logic       mclk,
  output logic            reg_wr_en,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_hit
);
  initial begin
    reg_wr_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  task automatic write(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == `ADDR_OPT1) v[6:5] = 2'h0;
    if (a == `ADDR_OPT2) v[5:2] = 4'hd;
    @(posedge mclk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr_en <= 1'b0;
    reg_wdata <= ~v;
  endtask

  task automatic read(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(posedge mclk);
    reg_addr <= a;
    @(posedge mclk);
    #1;
    d = reg_rdata;
    h = reg_hit;
  endtask
endmodule
`default_nettype wire

// *** sim/backlight_bias_status_option_regs_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "bias_regs_defines.svh"
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_count++; \
  $display("wrong value at %0t: got %h exp %h", $time, got, exp); end end
// ****************************************
// register bank bench
// ****************************************
module backlight_bias_status_option_regs_tb;
  import bias_regs_pkg::*;
  logic          mclk;
  logic          rst_n;
  logic [6:0]    flt;
  logic [10:0]   mdc;
  logic          wr_en;
  logic [7:0]    addr;
  logic [7:0]    wdata;
  logic [7:0]    rdata;
  logic          hit;
  logic [5:0]    nbo;
  logic          s2;
  logic          s1;
  logic          fast;
  glitch_sel_t   gsel;
  inductor_sel_t isel;
  logic [1:0]    gp;
  logic [1:0]    gi;
  ilim_sel_t     ilim;
  logic [7:0]    v;
  int            err_count;
  int            checks_done;
  int            i;
  logic [5:0]    nb_tab [5] = '{6'h00, 6'h1c, 6'h31, 6'h32, 6'h3f};
  logic [10:0]   cd_tab [3] = '{11'h5a7, 11'h7ff, 11'h2d8};

  bias_status_option_regs dut (.mclk(mclk), .rst_n(rst_n), .reg_wr_en(wr_en), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .reg_hit(hit), .thermal_trip_flag(flt[6]),
    .display_boost_overvoltage_flag(flt[5]), .positive_bias_overcurrent_flag(flt[3]),
    .negative_bias_short_flag(flt[2]), .backlight_overvoltage_flag(flt[1]),
    .backlight_overcurrent_flag(flt[0]), .measured_duty_code(mdc), .negative_bias_output(nbo),
    .string_two_sense_off(s2), .string_one_sense_off(s1), .pwm_glitch_width_select(gsel),
    .pwm_fast_sampling_select(fast), .inductor_select(isel), .loop_gain_p(gp), .loop_gain_i(gi),
    .switch_current_limit(ilim));

  reg_host_model host (.mclk(mclk), .reg_wr_en(wr_en), .reg_addr(addr), .reg_wdata(wdata),
    .reg_rdata(rdata), .reg_hit(hit));

  task automatic print_verdict;
    if (err_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       h;
    host.read(a, d, h);
    `CHK(d, e)
    `CHK(h, (a >= `ADDR_NEG_BIAS && a <= `ADDR_CODE_HI))
  endtask

  task automatic settle;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    print_verdict();
  end

  initial begin
    rst_n = 1'b0;
    flt = 7'h00;
    mdc = 11'h000;
    err_count = 0;
    checks_done = 0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    settle();
    // reset values
    rd_chk(`ADDR_NEG_BIAS, 8'h1c);
    rd_chk(`ADDR_FAULT, 8'h00);
    rd_chk(`ADDR_OPT1, 8'h06);
    rd_chk(`ADDR_OPT2, 8'h35);
    rd_chk(`ADDR_CODE_LO, 8'h00);
    rd_chk(`ADDR_CODE_HI, 8'h00);
    `CHK(nbo, 6'h1c)
    `CHK({gsel, s2, s1, fast, isel, gp, gi, ilim}, {2'h3, 3'h0, 2'h0, 2'h3, 2'h1, 2'h1})
    // fault flags one at a time, then all
    for (i = 0; i < 7; i++) begin
      if (i != 4) begin
        @(posedge mclk);
        flt <= 7'h01 << i;
        rd_chk(`ADDR_FAULT, 8'h01 << i);
      end
    end
    @(posedge mclk);
    flt <= 7'h7f;
    rd_chk(`ADDR_FAULT, 8'h6f);
    // read-only and unmapped writes
    @(posedge mclk);
    flt <= 7'h22;
    mdc <= 11'h3c5;
    host.write(`ADDR_FAULT, 8'hff);
    host.write(`ADDR_CODE_LO, 8'hff);
    host.write(`ADDR_CODE_HI, 8'hff);
    host.write(8'h20, 8'h5a);
    rd_chk(`ADDR_FAULT, 8'h22);
    rd_chk(`ADDR_CODE_LO, 8'hc5);
    rd_chk(`ADDR_CODE_HI, 8'h03);
    rd_chk(8'h20, 8'h00);
    // option one fields
    for (i = 0; i < 32; i++) begin
      v = {3'h0, i[4:0]};
      host.write(`ADDR_OPT1, v);
      settle();
      `CHK({s2, s1, gsel, fast}, v[4:0])
      rd_chk(`ADDR_OPT1, v);
    end
    // option two fields
    for (i = 0; i < 16; i++) begin
      v = {i[3:2], 4'hd, i[1:0]};
      host.write(`ADDR_OPT2, v);
      settle();
      `CHK(isel, (i[3] ? 2'h2 : {1'b0, i[2]}))
      `CHK({gp, gi, ilim}, {2'h3, 2'h1, v[1:0]})
      rd_chk(`ADDR_OPT2, v);
    end
    // negative bias codes and clamp
    for (i = 0; i < 5; i++) begin
      host.write(`ADDR_NEG_BIAS, {2'h0, nb_tab[i]});
      settle();
      `CHK(nbo, ((nb_tab[i] > 6'h32) ? 6'h32 : nb_tab[i]))
      rd_chk(`ADDR_NEG_BIAS, {2'h0, nb_tab[i]});
    end
    // mid-run reset brings back the defaults, fault image stays live
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    settle();
    rd_chk(`ADDR_NEG_BIAS, 8'h1c);
    rd_chk(`ADDR_OPT1, 8'h06);
    rd_chk(`ADDR_OPT2, 8'h35);
    rd_chk(`ADDR_FAULT, 8'h22);
    `CHK(nbo, 6'h1c)
    `CHK({gsel, ilim}, {2'h3, 2'h1})
    // duty code readback
    for (i = 0; i < 3; i++) begin
      @(posedge mclk);
      mdc <= cd_tab[i];
      rd_chk(`ADDR_CODE_LO, cd_tab[i][7:0]);
      rd_chk(`ADDR_CODE_HI, {5'h00, cd_tab[i][10:8]});
    end
    print_verdict();
  end
endmodule
`default_nettype wire
